// [tb/rfwl_fifo_monitor.sv]
`timescale 1ns/100ps
`include "rfwl_defs.vh"
module rfwl_fifo_monitor (
   // Clock and inputs
   input wire       mclk_i,
   input wire       arst_n_i,
   input wire       ss_n_i,
   input wire       op_en_i,
   input wire       tx_active_i,
   input wire       rx_start_i,
   input wire       rx_valid_i,
   input wire       rx_last_i,
   input wire       tx_take_i,
   input wire       stat2_read_i,
   // Outputs watched
   input wire       miso_oe_n_o,
   input wire [6:0] fifo_count_o,
   input wire [2:0] last_byte_valid_bits_o,
   input wire       last_byte_parity_flag_o,
   input wire       overflow_o,
   input wire       underflow_o,
   input wire       fifo_wl_evt_o,
   input wire       clear_evt_o
);
   // ----------------
   // Properties
   // ----------------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   evt_single_a: assert property (fifo_wl_evt_o |=> !fifo_wl_evt_o)
      else $error("event pulse too long");
   evt_quiet_a: assert property ((!ss_n_i) [*8] |-> !fifo_wl_evt_o)
      else $error("event while serial port busy");
   count_cap_a: assert property (fifo_count_o <= `RFWL_DEPTH)
      else $error("count above depth");
   ovf_set_a: assert property (rx_valid_i && !tx_active_i && ss_n_i
      && fifo_count_o == `RFWL_DEPTH |-> ##[1:4] overflow_o) else $error("no overflow");
   udf_set_a: assert property (tx_active_i && tx_take_i && fifo_count_o == 7'h00
      && $past(fifo_count_o, 2) == 7'h00 |-> ##[1:4] underflow_o) else $error("no underflow");
   rx_flush_a: assert property (rx_start_i |-> ##2 fifo_count_o == 7'h00 && !overflow_o)
      else $error("receive start kept data");
   stat_clr_a: assert property (stat2_read_i && !rx_last_i |-> ##[1:2]
      (last_byte_valid_bits_o == 3'h0 && !last_byte_parity_flag_o)) else $error("status kept");
   ss_idle_a: assert property (ss_n_i [*4] |-> miso_oe_n_o)
      else $error("output driven while deselected");
   clr_flush_a: assert property (clear_evt_o |-> op_en_i ##[0:3] fifo_count_o == 7'h00)
      else $error("clear misbehaved");
endmodule
bind rfwl_fifo rfwl_fifo_monitor u_mon (.*);

// [tb/rfwl_host_model.sv]
`timescale 1ns/100ps
module rfwl_host_model (
   // Serial port
   output reg  ss_n_o,
   output reg  sclk_o,
   output reg  mosi_o,
   input  wire miso_i
);
   // ----------------
   // Host frames
   // ----------------
   initial begin
      {ss_n_o, sclk_o, mosi_o} = 3'h4;
   end
   task start;
      begin
         ss_n_o = 1'b0;
         #40;
      end
   endtask
   task stop;
      begin
         #320;
         ss_n_o = 1'b1;
         mosi_o = ~mosi_o;
         #200;
      end
   endtask
   // 160 ns clock, MSB first; bit held 40 ns past the fall
   task xfer(input [7:0] d, input integer n, output [7:0] r);
      integer i;
      begin
         r = 8'h00;
         for (i = 7; i >= 8 - n; i--) begin
            mosi_o = d[i];
            #40 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
            r[i] = miso_i;
            #40;
         end
      end
   endtask
endmodule

// [tb/tb_rfwl_fifo.sv]
`timescale 1ns/100ps
`include "rfwl_defs.vh"
module tb_rfwl_fifo;
   reg        mclk_i, arst_n_i, op_en_i, rx_wl_sel_i, tx_wl_sel_i, tx_active_i;
   reg        rx_start_i, tx_frame_loaded_i, tx_below_wl_i, rx_valid_i, rx_last_i;
   reg        rx_last_parity_i, tx_take_i, stat2_read_i;
   reg  [7:0] rx_data_i, q;
   reg  [2:0] rx_last_bits_i;
   wire       ss_n_i, sclk_i, mosi_i, miso_o, miso_oe_n_o, tx_data_valid_o;
   wire       last_byte_incomplete_o, last_byte_parity_flag_o, overflow_o;
   wire       underflow_o, fifo_wl_evt_o, clear_evt_o;
   wire [7:0] tx_data_o;
   wire [6:0] fifo_count_o;
   wire [2:0] last_byte_valid_bits_o;
   integer    errors = 0, compares = 0, nevt = 0, cyc = 0, n0, i;
   rfwl_fifo dut (.*);
   rfwl_host_model host (.ss_n_o(ss_n_i), .sclk_o(sclk_i), .mosi_o(mosi_i), .miso_i(miso_o));
   // ----------------
   // Helpers
   // ----------------
   always #5 mclk_i = ~mclk_i;
   // Ceiling far above the few thousand cycles the tests need
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (fifo_wl_evt_o === 1'b1) nevt <= nevt + 1;
      if (cyc == 40000) begin
         errors = errors + 1;
         close_out;
      end
   end
   task cy(input integer n);
      begin
         repeat (n) @(posedge mclk_i);
         #1;
      end
   endtask
   task chk(input string n, input [7:0] s, input [7:0] e);
      begin
         compares++;
         if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   // Kind 0 rx byte, 1 take, 2 rx start, 3 status read
   task stb(input [1:0] k, input [7:0] d);
      begin
         cy(1);
         rx_data_i = d;
         {stat2_read_i, rx_start_i, tx_take_i, rx_valid_i} = 4'h1 << k;
         cy(1);
         {stat2_read_i, rx_start_i, tx_take_i, rx_valid_i} = 4'h0;
      end
   endtask
   task frame(input [7:0] h);
      begin
         host.start;
         host.xfer(h, 8, q);
         host.stop;
         cy(4);
      end
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task t_rx(input s, input [6:0] wl);
      begin
         rx_wl_sel_i = s;
         stb(2, 8'h00);
         n0 = nevt;
         for (i = 0; i < `RFWL_DEPTH; i++) begin
            stb(0, i[7:0]);
            if (i == wl - 2 || i == wl - 1) cy(5);
            if (i == wl - 2 || i == wl - 1) chk("wl_evt", 8'(nevt - n0), 8'(i - wl + 2));
         end
         cy(5);
         chk("evt_once", 8'(nevt - n0), 8'h01);
         chk("count", {1'b0, fifo_count_o}, {1'b0, `RFWL_DEPTH});
         stb(0, 8'hEE);
         cy(4);
         chk("overflow", {7'h00, overflow_o}, 8'h01);
         $display("t_rx done");
      end
   endtask
   task t_read;
      begin
         host.start;
         host.xfer(8'hBF, 8, q);
         for (i = 0; i < 2; i++) begin
            host.xfer(8'h00, 8, q);
            chk("rd_byte", q, i[7:0]);
         end
         host.xfer(8'h00, 4, q);
         host.stop;
         host.start;
         host.xfer(8'hBF, 8, q);
         host.xfer(8'h00, 8, q);
         chk("rd_cut", q, 8'h02);
         host.stop;
         cy(4);
         chk("count", {1'b0, fifo_count_o}, 8'd93);
         $display("t_read done");
      end
   endtask
   task t_quiet;
      begin
         stb(2, 8'h00);
         for (i = 1; i < `RFWL_RX_WL1; i++) stb(0, 8'h5A);
         cy(5);
         n0 = nevt;
         host.start;
         host.xfer(8'hBF, 8, q);
         stb(0, 8'h5A);
         cy(8);
         chk("quiet", 8'(nevt - n0), 8'h00);
         host.stop;
         rx_last_bits_i = 3'h5;
         rx_last_parity_i = 1'b1;
         rx_last_i = 1'b1;
         cy(1);
         rx_last_i = 1'b0;
         cy(3);
         chk("last", {last_byte_incomplete_o, last_byte_parity_flag_o, last_byte_valid_bits_o},
            8'h1D);
         stb(3, 8'h00);
         cy(3);
         chk("st2clr", {last_byte_incomplete_o, last_byte_valid_bits_o}, 8'h00);
         $display("t_quiet done");
      end
   endtask
   task t_tx;
      begin
         tx_active_i = 1'b1;
         op_en_i = 1'b0;
         frame(8'hC3);
         chk("clr_off", {1'b0, fifo_count_o}, {1'b0, `RFWL_RX_WL1});
         op_en_i = 1'b1;
         frame(`RFWL_DCMD_CLR0);
         chk("clr_on", {1'b0, fifo_count_o}, 8'h00);
         host.start;
         host.xfer(8'h80, 8, q);
         for (i = 0; i < 34; i++) host.xfer(8'h10 + i[7:0], 8, q);
         host.stop;
         cy(4);
         n0 = nevt;
         for (i = 0; i < 34; i++) begin
            if (i == 2) tx_below_wl_i = 1'b1;
            stb(1, 8'h00);
            chk("tx_data", {tx_data_valid_o, tx_data_o[6:0]}, 8'h90 + i[7:0]);
            if (i < 2 || i == 30) cy(5);
            if (i < 2) chk("tx_wl", 8'(nevt - n0), i[7:0]);
            if (i == 30) chk("low_fill", 8'(nevt - n0), 8'h02);
         end
         cy(4);
         stb(1, 8'h00);
         cy(4);
         chk("underflow", {7'h00, underflow_o}, 8'h01);
         $display("t_tx done");
      end
   endtask
   task close_out;
      begin
         $display("compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      {mclk_i, arst_n_i, rx_wl_sel_i, tx_wl_sel_i, tx_active_i, rx_start_i} = 6'h00;
      {tx_frame_loaded_i, tx_below_wl_i, rx_valid_i, rx_last_i} = 4'h0;
      {rx_last_parity_i, tx_take_i, stat2_read_i, rx_data_i, rx_last_bits_i} = 14'h0000;
      op_en_i = 1'b1;
      cy(3);
      arst_n_i = 1'b1;
      cy(3);
      t_rx(1'b0, `RFWL_RX_WL0);
      t_rx(1'b1, `RFWL_RX_WL1);
      t_read;
      t_quiet;
      t_tx;
      close_out;
   end
endmodule

// [verilog/rfwl_defs.vh]
// How it works
// - One 96-byte FIFO shared by transmit drain and receive fill.
// - Transmit, frame not yet loaded: pulse water-level event when count falls from level+1 to level.
// - Receive: pulse water-level event when count rises from level-1 to level.
// - Transmit, few bytes loaded: also pulse when count drops below 4.
// - No FIFO event while the serial port is in FIFO load or read mode.
// - FIFO mode lasts while slave-select is low; host raises it when done.
// - Two selectable water levels each for receive and transmit.
// - Start of reception empties FIFO and clears both status registers.
// - Live unread byte count is always visible.
// - Status shows incomplete last byte, its valid bit count and parity.
// - Incomplete flag, bit count and parity clear when status 2 is read.
// - Overflow flag sets on any write to a full FIFO.
// - Underflow flag sets on any read of an empty FIFO.
// - Clear command C2/C3 with enable set stops activity and empties FIFO.
// - FIFO read is mode bits 10 with six command bits all ones.
// - Byte cut short by slave-select rising stays unread for next read.
// - Bytes leave and enter the FIFO strictly in order.
`ifndef RFWL_DEFS_VH
`define RFWL_DEFS_VH
`define RFWL_DEPTH       7'd96
`define RFWL_LOW_FILL    7'd4
`define RFWL_RX_WL0      7'd80
`define RFWL_RX_WL1      7'd64
`define RFWL_TX_WL0      7'd32
`define RFWL_TX_WL1      7'd16
`define RFWL_MODE_FIFO   2'h2
`define RFWL_CMD_FIFORD  6'h3F
`define RFWL_CMD_FIFOLD  6'h00
`define RFWL_DCMD_CLR0   8'hC2
`define RFWL_DCMD_CLR1   8'hC3
`endif

// [verilog/rfwl_fifo.v]
`timescale 1ns/100ps
`include "rfwl_defs.vh"
module rfwl_fifo (
   // Clock and reset
   input  wire       mclk_i,
   input  wire       arst_n_i,
   // Serial port pins
   input  wire       ss_n_i,
   input  wire       sclk_i,
   input  wire       mosi_i,
   output reg        miso_o,
   output wire       miso_oe_n_o,
   // Configuration and mode
   input  wire       op_en_i,
   input  wire       rx_wl_sel_i,
   input  wire       tx_wl_sel_i,
   input  wire       tx_active_i,
   input  wire       rx_start_i,
   input  wire       tx_frame_loaded_i,
   input  wire       tx_below_wl_i,
   // Receive path
   input  wire       rx_valid_i,
   input  wire [7:0] rx_data_i,
   input  wire       rx_last_i,
   input  wire [2:0] rx_last_bits_i,
   input  wire       rx_last_parity_i,
   // Transmit path
   input  wire       tx_take_i,
   output reg  [7:0] tx_data_o,
   output reg        tx_data_valid_o,
   // Status
   input  wire       stat2_read_i,
   output reg  [6:0] fifo_count_o,
   output reg        last_byte_incomplete_o,
   output reg  [2:0] last_byte_valid_bits_o,
   output reg        last_byte_parity_flag_o,
   output reg        overflow_o,
   output reg        underflow_o,
   output reg        fifo_wl_evt_o,
   output reg        clear_evt_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------------------------------
   // Stage 0 is the metastable catcher and is read by nothing but stage 1.
   // Stage 2 is a plain delay of the settled value, used for edge detect.
   reg [2:0] ss_sync_reg;
   reg [2:0] sclk_sync_reg;
   reg [1:0] mosi_sync_reg;

   // Slave-select after synchronisation, high while the host holds it low
   wire ss_low   = ~ss_sync_reg[1];

   // Serial clock edges, seen two to three core clocks late
   wire sclk_r   = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   wire sclk_f   = ~sclk_sync_reg[1] & sclk_sync_reg[2];

   // Select edges; the decoder uses ss_fall to enter header state, ss_rise is kept for clarity only
   wire ss_rise  = ss_sync_reg[1] & ~ss_sync_reg[2];
   wire ss_fall  = ~ss_sync_reg[1] & ss_sync_reg[2];

   // Reset values match the idle pin levels, so no false edge follows reset
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ss_sync_reg   <= 3'h7;
         sclk_sync_reg <= 3'h0;
         mosi_sync_reg <= 2'h0;
      end else begin
         ss_sync_reg   <= {ss_sync_reg[1:0], ss_n_i};
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
      end
   end

   // The serial clock must stay slow against the core clock: each half
   // period has to span at least three core cycles for edges to be seen.

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // 96-byte buffer
   reg [7:0] mem_reg [0:95];
   reg [6:0] rd_ptr_reg;
   reg [6:0] wr_ptr_reg;
   reg [6:0] count_reg;


   // Pointer advance with wrap at the buffer depth.
   // Depth is not a power of two, so the wrap is an explicit compare.
   // Used by both pointers and by the read-ahead of the output byte.
   function [6:0] rfwl_inc;
      input [6:0] p;
      begin
         rfwl_inc = (p == `RFWL_DEPTH - 7'd1) ? 7'd0 : p + 7'd1;
      end
   endfunction

   // ----------------------------------------------------------------
   // Serial decoder
   // ----------------------------------------------------------------
   // Header byte arrives first; load or read mode then lasts until the
   // select line rises. Direct commands leave the decoder in header state
   // so that a further command may follow without deselecting.

   localparam ST_IDLE = 2'd0;
   localparam ST_HDR  = 2'd1;
   localparam ST_LOAD = 2'd2;
   localparam ST_READ = 2'd3;

   reg [1:0] st_reg;
   reg [2:0] bit_reg;
   reg [7:0] sh_reg;
   reg [7:0] out_reg;
   reg       out_taken_reg;

   // Byte being shifted in, completed with the bit sampled on this fall
   wire       hdr_done  = (st_reg == ST_HDR) && sclk_f && (bit_reg == 3'd7);
   wire [7:0] hdr_byte  = {sh_reg[6:0], mosi_sync_reg[1]};
   wire       load_done = (st_reg == ST_LOAD) && sclk_f && (bit_reg == 3'd7);
   // read header mode 10, command all ones
   wire go_read  = hdr_done && (hdr_byte == {`RFWL_MODE_FIFO, `RFWL_CMD_FIFORD});
   wire go_load  = hdr_done && (hdr_byte == {`RFWL_MODE_FIFO, `RFWL_CMD_FIFOLD});
   wire clr_cmd  = hdr_done && op_en_i &&
                   ((hdr_byte == `RFWL_DCMD_CLR0) || (hdr_byte == `RFWL_DCMD_CLR1));
   // a byte is consumed only after its eighth bit
   wire spi_rd   = (st_reg == ST_READ) && sclk_f && (bit_reg == 3'd7);
   // FIFO mode held while slave-select low
   wire fifo_mode = ss_low && ((st_reg == ST_LOAD) || (st_reg == ST_READ));


   // The data pin is driven only while the buffer is being read out
   assign miso_oe_n_o = ~(st_reg == ST_READ);

   // Outgoing bits change on the rising serial edge, so the host has the
   // whole high phase to sample them on its falling edge.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg  <= ST_IDLE;
         bit_reg <= 3'd0;
         sh_reg  <= 8'h00;
         miso_o  <= 1'b0;
      end else if (!ss_low) begin
         st_reg  <= ST_IDLE;
         bit_reg <= 3'd0;
      end else begin
         if (ss_fall || st_reg == ST_IDLE)
            st_reg <= ST_HDR;
         if (sclk_f) begin
            bit_reg <= bit_reg + 3'd1;
            sh_reg  <= hdr_byte;
            if (bit_reg == 3'd7) begin
               if (go_read)
                  st_reg <= ST_READ;
               else if (go_load)
                  st_reg <= ST_LOAD;
               else if (st_reg == ST_HDR)
                  st_reg <= ST_HDR;
            end
         end
         if (st_reg == ST_READ && sclk_r)
            miso_o <= out_reg[3'd7 - bit_reg];
      end
   end

   // ----------------------------------------------------------------
   // FIFO pointers, writes and reads
   // ----------------------------------------------------------------
   // While the host loads the buffer the receive path is blocked; the two
   // writers never meet in one cycle, which keeps the order strict.
   // in-order write sources
   wire       wr_req  = (st_reg == ST_LOAD) ? load_done : rx_valid_i & ~tx_active_i;
   wire [7:0] wr_data = (st_reg == ST_LOAD) ? hdr_byte : rx_data_i;
   wire       rd_req  = spi_rd | (tx_take_i & tx_active_i);
   wire       empty   = (count_reg == 7'd0);
   wire       full    = (count_reg == `RFWL_DEPTH);
   wire       do_wr   = wr_req & ~full;
   wire       do_rd   = rd_req & ~empty;
   wire       flush   = clr_cmd | rx_start_i;


   // Storage has no reset: its contents are meaningless while count is zero
   always @(posedge mclk_i) begin
      if (do_wr)
         mem_reg[wr_ptr_reg] <= wr_data;
   end

   // Flush wins over a write or read in the same cycle.
   // The output byte is fetched one byte ahead, so the first bit is ready
   // at the first rising serial edge after the read header.

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_ptr_reg      <= 7'd0;
         wr_ptr_reg      <= 7'd0;
         count_reg       <= 7'd0;
         out_reg         <= 8'h00;
         tx_data_o       <= 8'h00;
         tx_data_valid_o <= 1'b0;
         clear_evt_o     <= 1'b0;
      end else begin
         clear_evt_o     <= clr_cmd;
         tx_data_valid_o <= do_rd & tx_take_i & tx_active_i;
         if (flush) begin
            rd_ptr_reg <= 7'd0;
            wr_ptr_reg <= 7'd0;
            count_reg  <= 7'd0;
         end else begin
            if (do_wr)
               wr_ptr_reg <= rfwl_inc(wr_ptr_reg);
            if (do_rd)
               rd_ptr_reg <= rfwl_inc(rd_ptr_reg);
            if (do_wr && !do_rd)
               count_reg <= count_reg + 7'd1;
            else if (do_rd && !do_wr)
               count_reg <= count_reg - 7'd1;
         end
         if (go_read || (spi_rd && count_reg > 7'd1))
            out_reg <= mem_reg[spi_rd ? rfwl_inc(rd_ptr_reg) : rd_ptr_reg];
         if (do_rd && !spi_rd)
            tx_data_o <= mem_reg[rd_ptr_reg];
      end
   end

   // ----------------------------------------------------------------
   // Status and water level
   // ----------------------------------------------------------------
   // Events compare the count with its value one cycle earlier, so each
   // crossing gives one pulse however long the level is held.
   // A crossing made inside load or read mode is lost, not delayed.

   wire [6:0] rx_wl = rx_wl_sel_i ? `RFWL_RX_WL1 : `RFWL_RX_WL0;
   wire [6:0] tx_wl = tx_wl_sel_i ? `RFWL_TX_WL1 : `RFWL_TX_WL0;
   reg  [6:0] prev_cnt_reg;

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_cnt_reg            <= 7'd0;
         fifo_count_o            <= 7'd0;
         fifo_wl_evt_o           <= 1'b0;
         last_byte_incomplete_o  <= 1'b0;
         last_byte_valid_bits_o  <= 3'd0;
         last_byte_parity_flag_o <= 1'b0;
         overflow_o              <= 1'b0;
         underflow_o             <= 1'b0;
      end else begin
         prev_cnt_reg <= count_reg;
         fifo_count_o <= count_reg;
         fifo_wl_evt_o <= ~fifo_mode & (prev_cnt_reg != count_reg) & (
            (tx_active_i & ~tx_frame_loaded_i &
             prev_cnt_reg == tx_wl + 7'd1 && count_reg == tx_wl) |
            (tx_active_i & ~tx_frame_loaded_i & tx_below_wl_i &
             prev_cnt_reg == `RFWL_LOW_FILL && count_reg == `RFWL_LOW_FILL - 7'd1) |
            (~tx_active_i & prev_cnt_reg == rx_wl - 7'd1 && count_reg == rx_wl));

         // Error flags are sticky until the next reception or clear
         if (rx_start_i || clr_cmd) begin
            last_byte_incomplete_o  <= 1'b0;
            last_byte_valid_bits_o  <= 3'd0;
            last_byte_parity_flag_o <= 1'b0;
            overflow_o              <= 1'b0;
            underflow_o             <= 1'b0;
         end else begin
            // last byte status, set wins over read clear
            if (rx_last_i) begin
               last_byte_incomplete_o  <= (rx_last_bits_i != 3'd0);
               last_byte_valid_bits_o  <= rx_last_bits_i;
               last_byte_parity_flag_o <= rx_last_parity_i;
            end else if (stat2_read_i) begin
               last_byte_incomplete_o  <= 1'b0;
               last_byte_valid_bits_o  <= 3'd0;
               last_byte_parity_flag_o <= 1'b0;
            end
            if (wr_req && full)
               overflow_o <= 1'b1;
            if (rd_req && empty)
               underflow_o <= 1'b1;
         end
      end
   end

endmodule
